// [design/uie_regs.svh]
`ifndef UIE_REGS_SVH
`define UIE_REGS_SVH
// Register byte offsets
`define UIE_OFS_DATA 12'h000
`define UIE_OFS_FLAG 12'h018
`define UIE_OFS_LPDIV 12'h020
`define UIE_OFS_IBRD 12'h024
`define UIE_OFS_FBRD 12'h028
`define UIE_OFS_LCR 12'h02C
`define UIE_OFS_CR 12'h030
`define UIE_OFS_IFLS 12'h034
`define UIE_OFS_DMACR 12'h048
`define UIE_OFS_ID 12'hFE0
// Line control fields
`define UIE_LCR_BRK 0
`define UIE_LCR_PEN 1
`define UIE_LCR_EPS 2
`define UIE_LCR_STP2 3
`define UIE_LCR_FEN 4
`define UIE_LCR_WORD_LENGTH_FIELD_LO 5
// Control fields
`define UIE_CR_EN 0
`define UIE_CR_IR 1
`define UIE_CR_IRLP 2
`define UIE_CR_TXE 8
`define UIE_CR_RXE 9
`define UIE_CR_RTS 11
`define UIE_CR_RTSEN 14
`define UIE_CR_CTSEN 15
// Reset values
`define UIE_CR_RST 16'h0300
`define UIE_LCR_RST 8'h00
`define UIE_IFLS_RST 6'h12
`define UIE_IBRD_RST 16'h0000
`define UIE_FBRD_RST 6'h00
// Timing
`define UIE_CLK_HZ 25000000
`define UIE_LP_TICK_HZ 1842000
`define UIE_LPDIV_RST 8'(`UIE_CLK_HZ / `UIE_LP_TICK_HZ)
`define UIE_OS_TICKS 4'hF
`define UIE_IR_PULSE_TICKS 4'h3
`define UIE_LP_PULSE_TICKS 2'h3
`define UIE_BRK_TICKS 8'hC0
`define UIE_FRAC_ONE 23'h000040
`endif

// [design/uie_pkg.sv]
package uie_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uie_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRKW} uie_rx_state_t;
  typedef logic [3:0] uie_rx_status_t; // {overrun, break, parity, framing}
endpackage

// [design/uie_fifo_if.sv]
`timescale 1ns/10ps
interface uie_fifo_if #(parameter int W = 8, parameter int AW = 4);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic single;
  logic [W-1:0] rdata;
  logic full;
  logic empty;
  logic [AW:0] count;
  modport fifo (input push, wdata, pop, single, output rdata, full, empty, count);
  modport user (output push, wdata, pop, single, input rdata, full, empty, count);
endinterface // uie_fifo_if

// [design/uie_fifo.sv]
`timescale 1ns/10ps
module uie_fifo #(
  parameter int W = 8,
  parameter int AW = 4
) (
  input wire logic clk, // Reference clock
  input wire logic reset, // Synchronous reset
  uie_fifo_if.fifo f // Queue port
);
  localparam int D = 1 << AW;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire do_push = f.push & ~f.full;
  wire do_pop = f.pop & ~f.empty;

  // With the queue off only one entry is held
  assign f.full = f.single ? (cnt_q != '0) : (cnt_q == (AW+1)'(D));
  assign f.empty = (cnt_q == '0);
  assign f.count = cnt_q;
  assign f.rdata = mem_q[rp_q];

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= wp_q + 1'b1;
      if (do_pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Storage has no reset
  always_ff @(posedge clk) begin
    if (do_push) mem_q[wp_q] <= f.wdata;
  end
endmodule // uie_fifo

// [design/uie_top.sv]
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps
`include "uie_regs.svh"
module uie_top #(
  parameter logic [31:0] PORT_ID = 32'h0000_1A5E // Value is arbitrary
) (
  input wire logic clk, // Reference clock, 25 MHz
  input wire logic reset, // Synchronous, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic rxd, // Serial input
  output logic txd, // Serial output
  input wire logic ir_in, // Infrared receive, high pulse is a 0
  output logic ir_serial_out, // Infrared transmit pulses
  input wire logic cts_n, // Clear to send, active low
  output logic rts_n, // Request to send, active low
  output logic tx_dma_req, // Transmit DMA request
  output logic rx_dma_req // Receive DMA request
);
  uie_fifo_if #(.W(8), .AW(4)) txf ();
  uie_fifo_if #(.W(12), .AW(4)) rxf ();
  uie_fifo #(.W(8), .AW(4)) u_txq (.clk(clk), .reset(reset), .f(txf));
  uie_fifo #(.W(12), .AW(4)) u_rxq (.clk(clk), .reset(reset), .f(rxf));

  // Trigger fraction to entry count
  function automatic logic [4:0] lvl(input logic [2:0] sel);
    case (sel)
      3'h0: lvl = 5'h02;
      3'h1: lvl = 5'h04;
      3'h2: lvl = 5'h08;
      3'h3: lvl = 5'h0C;
      default: lvl = 5'h0E;
    endcase
  endfunction

  // Keeps only the configured number of data bits
  function automatic logic [7:0] wmask(input logic [7:0] d, input logic [1:0] wl);
    wmask = d & (8'hFF >> (2'h3 - wl));
  endfunction

  logic [15:0] cr_q;
  logic [7:0] lcr_q;
  logic [5:0] ifls_q;
  logic [15:0] ibrd_q;
  logic [5:0] fbrd_q;
  logic [7:0] lpdiv_q;
  logic [1:0] dmacr_q;
  logic [21:0] acc_q;
  logic tick_q;
  logic [7:0] lpc_q;
  logic lptick_q;
  logic ovr_q;

  // Configuration decode
  wire en_w = cr_q[`UIE_CR_EN];
  wire ir_w = cr_q[`UIE_CR_IR];
  wire irlp_w = cr_q[`UIE_CR_IRLP];
  wire pen_w = lcr_q[`UIE_LCR_PEN];
  wire eps_w = lcr_q[`UIE_LCR_EPS];
  wire fen_w = lcr_q[`UIE_LCR_FEN];
  wire [1:0] word_length_field_w = lcr_q[`UIE_LCR_WORD_LENGTH_FIELD_LO +: 2];
  wire [2:0] lastbit_w = {1'b0, word_length_field_w} + 3'h4;

  // APB phases: answer in the first access cycle, act at its edge
  wire setup_w = psel & ~penable;
  wire done_w = psel & penable & pready;
  wire wr_w = done_w & pwrite;
  wire sel_data = (paddr == `UIE_OFS_DATA);
  wire sel_flag = (paddr == `UIE_OFS_FLAG);
  wire sel_lpdiv = (paddr == `UIE_OFS_LPDIV);
  wire sel_ibrd = (paddr == `UIE_OFS_IBRD);
  wire sel_fbrd = (paddr == `UIE_OFS_FBRD);
  wire sel_lcr = (paddr == `UIE_OFS_LCR);
  wire sel_cr = (paddr == `UIE_OFS_CR);
  wire sel_ifls = (paddr == `UIE_OFS_IFLS);
  wire sel_dmacr = (paddr == `UIE_OFS_DMACR);
  wire sel_id = (paddr == `UIE_OFS_ID);
  wire mapped_w = sel_data | sel_flag | sel_lpdiv | sel_ibrd | sel_fbrd | sel_lcr | sel_cr | sel_ifls
                  | sel_dmacr | sel_id;

  // Queue levels against the selected trigger
  wire rx_hit_w = fen_w ? (rxf.count >= lvl(ifls_q[5:3])) : ~rxf.empty;
  wire tx_hit_w = fen_w ? (txf.count <= lvl(ifls_q[2:0])) : ~txf.full;

  uie_pkg::uie_tx_state_t tx_st_q;
  uie_pkg::uie_rx_state_t rx_st_q;
  wire busy_w = (tx_st_q != uie_pkg::TX_IDLE) | ~txf.empty;
  wire [31:0] flag_w = {22'h0, tx_hit_w, rx_hit_w, txf.empty, rxf.full, txf.full, rxf.empty, busy_w,
                        2'h0, ~cts_n};

  // Read selection
  wire [31:0] rd_w = sel_data ? {20'h0, rxf.rdata} :
                     sel_flag ? flag_w :
                     sel_lpdiv ? {24'h0, lpdiv_q} :
                     sel_ibrd ? {16'h0, ibrd_q} :
                     sel_fbrd ? {26'h0, fbrd_q} :
                     sel_lcr ? {24'h0, lcr_q} :
                     sel_cr ? {16'h0, cr_q} :
                     sel_ifls ? {26'h0, ifls_q} :
                     sel_dmacr ? {30'h0, dmacr_q} :
                     sel_id ? PORT_ID : 32'h0;

  // Bus answer and control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      cr_q <= `UIE_CR_RST;
      lcr_q <= `UIE_LCR_RST;
      ifls_q <= `UIE_IFLS_RST;
      ibrd_q <= `UIE_IBRD_RST;
      fbrd_q <= `UIE_FBRD_RST;
      lpdiv_q <= `UIE_LPDIV_RST;
      dmacr_q <= 2'h0;
    end else begin
      pready <= setup_w;
      pslverr <= setup_w & ~mapped_w;
      if (setup_w) prdata <= rd_w;
      if (wr_w & sel_cr) cr_q <= pwdata[15:0];
      if (wr_w & sel_lcr) lcr_q <= pwdata[7:0];
      if (wr_w & sel_ifls) ifls_q <= pwdata[5:0];
      if (wr_w & sel_ibrd) ibrd_q <= pwdata[15:0];
      if (wr_w & sel_fbrd) fbrd_q <= pwdata[5:0];
      if (wr_w & sel_lpdiv) lpdiv_q <= pwdata[7:0];
      if (wr_w & sel_dmacr) dmacr_q <= pwdata[1:0];
    end
  end

  // Data register writes push, reads pop after the access completes
  assign txf.push = wr_w & sel_data;
  assign txf.wdata = pwdata[7:0];
  assign rxf.pop = done_w & ~pwrite & sel_data;
  assign txf.single = ~fen_w;
  assign rxf.single = ~fen_w;

  // Fractional divisor in 1/64 steps; a divisor under one tick gives a tick every clock
  wire [21:0] div_w = {ibrd_q, fbrd_q};
  wire [22:0] acc_sum_w = {1'b0, acc_q} + `UIE_FRAC_ONE;
  wire small_w = ({1'b0, div_w} < `UIE_FRAC_ONE);
  wire tick_w = en_w & (small_w | (acc_sum_w >= {1'b0, div_w}));
  always_ff @(posedge clk) begin
    if (reset | ~en_w | small_w) acc_q <= 22'h0;
    else acc_q <= tick_w ? 22'(acc_sum_w - {1'b0, div_w}) : acc_sum_w[21:0];
    tick_q <= ~reset & tick_w;
  end

  // Low-power infrared tick divider
  wire lp_wrap_w = (lpc_q <= 8'h01);
  always_ff @(posedge clk) begin
    if (reset) lpc_q <= 8'h0;
    else lpc_q <= lp_wrap_w ? lpdiv_q : lpc_q - 8'h01;
    lptick_q <= ~reset & lp_wrap_w;
  end

  // Transmitter
  logic [3:0] tcnt_q;
  logic [2:0] tbit_q;
  logic [7:0] tsh_q;
  logic tstop_q;
  logic [7:0] brk_q;
  logic [1:0] lpp_q;
  logic lparm_q;
  wire cts_ok_w = ~cr_q[`UIE_CR_CTSEN] | ~cts_n;
  wire tx_go_w = tick_q & en_w & cr_q[`UIE_CR_TXE] & ~txf.empty & cts_ok_w;
  wire tend_w = tick_q & (tcnt_q == `UIE_OS_TICKS);
  wire tpar_w = eps_w ? ^wmask(tsh_q, word_length_field_w) : ~^wmask(tsh_q, word_length_field_w);
  wire tx_bit_w = (tx_st_q == uie_pkg::TX_START) ? 1'b0 :
                  (tx_st_q == uie_pkg::TX_DATA) ? tsh_q[tbit_q] :
                  (tx_st_q == uie_pkg::TX_PAR) ? tpar_w : 1'b1;
  wire brk_on_w = lcr_q[`UIE_LCR_BRK] | (brk_q != 8'h0);
  assign txf.pop = (tx_st_q == uie_pkg::TX_IDLE) & tx_go_w;

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_st_q <= uie_pkg::TX_IDLE;
      tcnt_q <= 4'h0;
      tbit_q <= 3'h0;
      tsh_q <= 8'h0;
      tstop_q <= 1'b0;
    end else begin
      if (tick_q) tcnt_q <= tcnt_q + 4'h1;
      case (tx_st_q)
        uie_pkg::TX_IDLE: begin
          tcnt_q <= 4'h0;
          if (tx_go_w) begin
            tsh_q <= txf.rdata;
            tx_st_q <= uie_pkg::TX_START;
          end
        end
        uie_pkg::TX_START: begin
          if (tend_w) begin
            tbit_q <= 3'h0;
            tx_st_q <= uie_pkg::TX_DATA;
          end
        end
        uie_pkg::TX_DATA: begin
          if (tend_w) begin
            tbit_q <= tbit_q + 3'h1;
            tstop_q <= lcr_q[`UIE_LCR_STP2];
            if (tbit_q == lastbit_w) tx_st_q <= pen_w ? uie_pkg::TX_PAR : uie_pkg::TX_STOP;
          end
        end
        uie_pkg::TX_PAR: begin
          if (tend_w) tx_st_q <= uie_pkg::TX_STOP;
        end
        uie_pkg::TX_STOP: begin
          if (tend_w) begin
            tstop_q <= 1'b0;
            if (!tstop_q) tx_st_q <= uie_pkg::TX_IDLE;
          end
        end
        default: tx_st_q <= uie_pkg::TX_IDLE;
      endcase
    end
  end

  // Break holds the line low for at least a longest frame of ticks
  always_ff @(posedge clk) begin
    if (reset) brk_q <= 8'h0;
    else if (lcr_q[`UIE_LCR_BRK]) brk_q <= `UIE_BRK_TICKS;
    else if (tick_q && brk_q != 8'h0) brk_q <= brk_q - 8'h01;
  end

  // Low-power pulse is timed by its own tick so it stays short at slow rates
  wire lp_start_w = (tcnt_q == 4'h0) & ~tx_bit_w & ~lparm_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      lpp_q <= 2'h0;
      lparm_q <= 1'b0;
    end else begin
      if (lp_start_w) lpp_q <= `UIE_LP_PULSE_TICKS;
      else if (lptick_q && lpp_q != 2'h0) lpp_q <= lpp_q - 2'h1;
      lparm_q <= (tcnt_q == 4'h0) & ~tx_bit_w;
    end
  end

  // Line drivers; in infrared mode the wired output rests high
  wire ir_pulse_w = irlp_w ? (lpp_q != 2'h0) : (~tx_bit_w & (tcnt_q < `UIE_IR_PULSE_TICKS));
  always_ff @(posedge clk) begin
    if (reset) begin
      txd <= 1'b1;
      ir_serial_out <= 1'b0;
    end else begin
      txd <= (ir_w | ~brk_on_w) & (ir_w | tx_bit_w);
      ir_serial_out <= en_w & ir_w & (brk_on_w | ir_pulse_w);
    end
  end

  // Infrared receive: each short pulse is stretched into a half-bit low
  logic [3:0] irs_q;
  always_ff @(posedge clk) begin
    if (reset) irs_q <= 4'h0;
    else if (ir_in) irs_q <= 4'h8;
    else if (tick_q && irs_q != 4'h0) irs_q <= irs_q - 4'h1;
  end
  wire rline_w = ir_w ? (irs_q == 4'h0) : rxd;

  // Receiver
  logic [3:0] rcnt_q;
  logic [2:0] rbit_q;
  logic [7:0] rsh_q;
  logic rpe_q;
  logic rzero_q;
  wire rend_w = tick_q & (rcnt_q == `UIE_OS_TICKS);
  wire [3:0] rchk_w = ir_w ? 4'h3 : 4'h7;
  wire rpexp_w = eps_w ? ^wmask(rsh_q, word_length_field_w) : ~^wmask(rsh_q, word_length_field_w);
  wire rstop_w = (rx_st_q == uie_pkg::RX_STOP) & rend_w;
  uie_pkg::uie_rx_status_t rstat_w;
  assign rstat_w = {ovr_q, ~rline_w & rzero_q, rpe_q, ~rline_w};
  assign rxf.push = rstop_w;
  assign rxf.wdata = {rstat_w, rsh_q};

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_st_q <= uie_pkg::RX_IDLE;
      rcnt_q <= 4'h0;
      rbit_q <= 3'h0;
      rsh_q <= 8'h0;
      rpe_q <= 1'b0;
      rzero_q <= 1'b0;
    end else begin
      if (tick_q) rcnt_q <= rcnt_q + 4'h1;
      case (rx_st_q)
        uie_pkg::RX_IDLE: begin
          rcnt_q <= 4'h0;
          rsh_q <= 8'h0;
          rbit_q <= 3'h0;
          rpe_q <= 1'b0;
          rzero_q <= 1'b1;
          if (en_w && cr_q[`UIE_CR_RXE] && !rline_w) rx_st_q <= uie_pkg::RX_START;
        end
        uie_pkg::RX_START: begin
          if (tick_q && rcnt_q == rchk_w) begin
            rcnt_q <= 4'h0;
            rx_st_q <= rline_w ? uie_pkg::RX_IDLE : uie_pkg::RX_DATA;
          end
        end
        uie_pkg::RX_DATA: begin
          if (rend_w) begin
            rsh_q[rbit_q] <= rline_w;
            rbit_q <= rbit_q + 3'h1;
            if (rline_w) rzero_q <= 1'b0;
            if (rbit_q == lastbit_w) rx_st_q <= pen_w ? uie_pkg::RX_PAR : uie_pkg::RX_STOP;
          end
        end
        uie_pkg::RX_PAR: begin
          if (rend_w) begin
            rpe_q <= (rline_w != rpexp_w);
            if (rline_w) rzero_q <= 1'b0;
            rx_st_q <= uie_pkg::RX_STOP;
          end
        end
        uie_pkg::RX_STOP: begin
          if (rend_w) rx_st_q <= rline_w ? uie_pkg::RX_IDLE : uie_pkg::RX_BRKW;
        end
        uie_pkg::RX_BRKW: begin
          if (rline_w) rx_st_q <= uie_pkg::RX_IDLE;
        end
        default: rx_st_q <= uie_pkg::RX_IDLE;
      endcase
    end
  end

  // Overrun rides on the next stored character; a new loss wins over the clear
  always_ff @(posedge clk) begin
    if (reset) ovr_q <= 1'b0;
    else if (rstop_w && rxf.full) ovr_q <= 1'b1;
    else if (rstop_w) ovr_q <= 1'b0;
  end

  // Flow control and DMA requests
  always_ff @(posedge clk) begin
    if (reset) begin
      rts_n <= 1'b1;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      rts_n <= cr_q[`UIE_CR_RTSEN] ? rxf.full : ~cr_q[`UIE_CR_RTS];
      tx_dma_req <= dmacr_q[1] & tx_hit_w;
      rx_dma_req <= dmacr_q[0] & rx_hit_w;
    end
  end
endmodule // uie_top

// [tb/uie_top_sva.sv]
`timescale 1ns/10ps
module uie_chk (
  input wire logic clk, // Reference clock
  input wire logic reset, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic txd, // Serial out
  input wire logic ir_serial_out, // Infrared out
  input wire logic rts_n, // Request to send
  input wire logic tx_dma_req, // Transmit DMA
  input wire logic rx_dma_req // Receive DMA
);
  // One domain, so clock and reset are set once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Start bit is two spans of eight, since repetition stays short
  sequence low8_s;
    !txd [*8];
  endsequence
  sequence pulse3_s;
    ir_serial_out [*3];
  endsequence
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_prdata_holds: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved without setup");
  chk_error_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response without ready or with data");
  chk_start_bit_len: assert property ($fell(txd) |-> low8_s ##1 low8_s)
    else $error("start bit shorter than sixteen ticks");
  chk_ir_pulse_min: assert property ($rose(ir_serial_out) |-> pulse3_s)
    else $error("infrared pulse shorter than three ticks");
  chk_ir_pulse_ends: assert property ($rose(ir_serial_out) |-> ##[3:1000] !ir_serial_out)
    else $error("infrared pulse never ends");
  chk_ir_txd_high: assert property (ir_serial_out |-> txd)
    else $error("txd low while infrared pulses");
  // Reset is the antecedent here, so this one alone is never disabled
  chk_reset_idle: assert property (disable iff (1'b0) reset |=> txd && rts_n && !pready &&
    !tx_dma_req && !rx_dma_req)
    else $error("outputs not idle after reset");
endmodule // uie_chk

bind uie_top uie_chk uie_chk_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd), .ir_serial_out(ir_serial_out), .rts_n(rts_n),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));

// [tb/uie_remote_dev.sv]
`timescale 1ns/10ps
module uie_remote_dev (
  input wire logic clk, // Shared reference clock
  input wire logic txd, // Line from the block
  output logic rxd, // Line into the block
  output logic ir_in // Infrared line, pulsed by ir_send
);
  // Idle line rests high; infrared receiver stays dark
  initial begin
    rxd = 1'b1;
    ir_in = 1'b0;
  end
  // Drive n bits LSB first, bp clocks each, then back to idle
  task automatic send(input logic [15:0] bits, input int n, input int bp);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bp) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // Infrared frame: a zero is a short high pulse at the head of its bit, a one stays dark
  task automatic ir_send(input logic [15:0] bits, input int n, input int bp);
    for (int i = 0; i < n; i++) begin
      ir_in <= ~bits[i];
      repeat (3) @(posedge clk);
      ir_in <= 1'b0;
      repeat (bp - 3) @(posedge clk);
    end
  endtask
  // Short low pulse that must not pass as a start bit
  task automatic glitch(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
  endtask
  // Sample mid-bit; a missing frame leaves all ones
  task automatic grab(input int n, input int bp, output logic [15:0] bits);
    int k;
    bits = 16'hFFFF;
    for (k = 0; k < 2000 && txd !== 1'b0; k++) @(posedge clk);
    if (k == 2000) return;
    bits = 16'h0000;
    repeat (bp / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (bp) @(posedge clk);
    end
  endtask
endmodule // uie_remote_dev

// [tb/tb_top.sv]
`timescale 1ns/10ps
`include "uie_regs.svh"
module tb_top;
  logic clk, reset, psel, penable, pwrite, cts_n, pready, pslverr;
  logic rxd, txd, ir_in, ir_serial_out, rts_n, tx_dma_req, rx_dma_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_errors = 0;
  int samples_checked = 0;
  localparam logic [31:0] ID_VAL = 32'h0000_C3D1; // Value is arbitrary
  uie_top #(.PORT_ID(ID_VAL)) uie_top_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .ir_in(ir_in), .ir_serial_out(ir_serial_out), .cts_n(cts_n), .rts_n(rts_n),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  uie_remote_dev uie_remote_dev_inst (.clk(clk), .txd(txd), .rxd(rxd), .ir_in(ir_in));
  // 25 MHz reference clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; answer and data are taken at the rising edge that sees pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, x, r & m);
  endtask
  // Poll one flag bit with a bounded count
  task automatic wait_flag(input int b, input logic v);
    logic [31:0] r;
    logic e;
    int k;
    for (k = 0; k < 1000; k++) begin
      apb(1'b0, `UIE_OFS_FLAG, 32'h0, r, e);
      if (r[b] === v) break;
    end
    if (k == 1000) begin
      n_errors++;
      print_verdict();
    end
  endtask
  // Divisor before line control, so the new rate is in place first
  task automatic cfg(input logic [15:0] ib, input logic [5:0] fb, input logic [7:0] lcr, input logic [15:0] cr);
    wr(`UIE_OFS_IBRD, {16'h0, ib});
    wr(`UIE_OFS_FBRD, {26'h0, fb});
    wr(`UIE_OFS_LCR, {24'h0, lcr});
    wr(`UIE_OFS_CR, {16'h0, cr});
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rdchk("cr", `UIE_OFS_CR, 32'h0000_0300);
    rdchk("lcr", `UIE_OFS_LCR, 32'h0000_0000);
    rdchk("ifls", `UIE_OFS_IFLS, 32'h0000_0012);
    rdchk("flag", `UIE_OFS_FLAG, 32'h0000_0290);
    rdchk("id", `UIE_OFS_ID, ID_VAL);
    rdchk("unmapped", 12'h004, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b0, `UIE_OFS_ID, 32'h0, r, e);
    chk("mapped_err", 32'h0, {31'h0, e});
  endtask
  task automatic t_tx();
    logic [15:0] b;
    cfg(16'h0001, 6'h20, 8'h70, 16'h0301);
    wr(`UIE_OFS_DATA, 32'h0000_00A5);
    uie_remote_dev_inst.grab(10, 24, b);
    chk("tx_8n1", {22'h0, 1'b1, 8'hA5, 1'b0}, {16'h0, b});
    cfg(16'h0002, 6'h00, 8'h1E, 16'h0301);
    wr(`UIE_OFS_DATA, 32'h0000_0016);
    uie_remote_dev_inst.grab(9, 32, b);
    chk("tx_5e2", {23'h0, 2'h3, 1'b1, 5'h16, 1'b0}, {16'h0, b});
  endtask
  task automatic t_rx();
    logic [7:0] d [4] = '{8'h3C, 8'h81, 8'h07, 8'h00};
    logic [3:0] st [4] = '{4'h0, 4'h1, 4'h2, 4'h5};
    logic [3:0] sp = 4'h5;
    cfg(16'h0001, 6'h00, 8'h76, 16'h0B01);
    // Control lands at the write edge and the pin follows one edge later
    repeat (2) @(posedge clk);
    chk("rts_n", 32'h0, {31'h0, rts_n});
    for (int i = 0; i < 4; i++) begin
      uie_remote_dev_inst.send({5'h0, sp[i], 1'b0, d[i], 1'b0}, 11, 16);
      wait_flag(4, 1'b0);
      rdchk("rx_char", `UIE_OFS_DATA, {20'h0, st[i], d[i]});
    end
  endtask
  task automatic t_false();
    uie_remote_dev_inst.glitch(5);
    repeat (200) @(posedge clk);
    rdchk("false_start", `UIE_OFS_FLAG, 32'h0000_0010, 32'h0000_0010);
  endtask
  task automatic t_fifo();
    cfg(16'h0001, 6'h00, 8'h60, 16'h0300);
    wr(`UIE_OFS_DATA, 32'h0000_0011);
    rdchk("flag_single", `UIE_OFS_FLAG, 32'h0000_0030, 32'h0000_03F0);
    wr(`UIE_OFS_CR, 32'h0000_0301);
    wait_flag(7, 1'b1);
    wr(`UIE_OFS_CR, 32'h0000_0300);
    wr(`UIE_OFS_LCR, 32'h0000_0070);
    for (int i = 0; i < 15; i++) wr(`UIE_OFS_DATA, 32'(i));
    rdchk("flag_15", `UIE_OFS_FLAG, 32'h0000_0010, 32'h0000_03F0);
    wr(`UIE_OFS_DATA, 32'h0000_00EE);
    rdchk("flag_16", `UIE_OFS_FLAG, 32'h0000_0030, 32'h0000_03F0);
    wr(`UIE_OFS_DMACR, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("tx_dma_full", 32'h0, {31'h0, tx_dma_req});
    wr(`UIE_OFS_CR, 32'h0000_0301);
    wait_flag(7, 1'b1);
    chk("tx_dma_empty", 32'h1, {31'h0, tx_dma_req});
  endtask
  task automatic t_brk();
    wr(`UIE_OFS_LCR, 32'h0000_0071);
    repeat (20) @(posedge clk);
    chk("txd_brk", 32'h0, {31'h0, txd});
    wr(`UIE_OFS_LCR, 32'h0000_0070);
    repeat (100) @(posedge clk);
    chk("txd_brk_hold", 32'h0, {31'h0, txd});
    repeat (150) @(posedge clk);
    chk("txd_idle", 32'h1, {31'h0, txd});
  endtask
  // Infrared receive with the queue off, so one character raises the receive request
  task automatic t_irrx();
    wr(`UIE_OFS_LCR, 32'h0000_0060);
    wr(`UIE_OFS_DMACR, 32'h0000_0001);
    wr(`UIE_OFS_CR, 32'h0000_0303);
    uie_remote_dev_inst.ir_send({6'h3F, 1'b1, 8'h5A, 1'b0}, 10, 16);
    wait_flag(4, 1'b0);
    chk("rx_dma_full", 32'h1, {31'h0, rx_dma_req});
    rdchk("ir_rx_char", `UIE_OFS_DATA, 32'h0000_005A);
    repeat (2) @(posedge clk);
    chk("rx_dma_empty", 32'h0, {31'h0, rx_dma_req});
  endtask
  // Count rising edges and high cycles of the infrared output
  task automatic ir_scan(output int n, output int w);
    logic p;
    p = 1'b0;
    n = 0;
    w = 0;
    repeat (200) begin
      @(posedge clk);
      n += (ir_serial_out && !p) ? 1 : 0;
      w += ir_serial_out ? 1 : 0;
      p = ir_serial_out;
    end
  endtask
  task automatic t_ir();
    int n, w;
    wr(`UIE_OFS_CR, 32'h0000_0303);
    wr(`UIE_OFS_DATA, 32'h0000_000F);
    ir_scan(n, w);
    chk("ir_pulses", 32'h5, 32'(n));
    chk("ir_high", 32'hF, 32'(w));
    chk("txd_ir", 32'h1, {31'h0, txd});
    wr(`UIE_OFS_CR, 32'h0000_0307);
    wr(`UIE_OFS_DATA, 32'h0000_00FF);
    ir_scan(n, w);
    chk("lp_pulses", 32'h1, 32'(n));
    chk("lp_width", 32'h1, {31'h0, w >= 27 && w <= 39});
  endtask
  // Bound on the whole run
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cts_n = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_false();
    t_fifo();
    t_brk();
    // Infrared receive runs before any infrared send, so no send-to-receive turnaround is needed
    t_irrx();
    t_ir();
    print_verdict();
  end
endmodule // tb_top
